//--- verilog/gir_pkg.sv
// Shared constants for the grouped interrupt register block.
package gir_pkg;
   localparam int GIR_MAX_GROUPS = 64;
   localparam int GIR_LINES_PER_GROUP = 32;
   localparam int GIR_NUM_LEVELS = 4;
   localparam int GIR_ADDR_W = 12;
   localparam int GIR_IDX_W = 10;
   localparam int GIR_GROUP_W = 6;
   localparam int GIR_LEVEL_W = 2;
   localparam int GIR_OFFSET_W = 14;
   localparam int GIR_PRIO_W = GIR_LEVEL_W + GIR_OFFSET_W;
   // Printed offsets are register indices; the byte address is four times the index.
   localparam logic [GIR_IDX_W-1:0] GIR_PRIO_BASE_IDX = 10'h000;
   localparam logic [GIR_IDX_W-1:0] GIR_LINES_BASE_IDX = 10'h0ff;
   localparam logic [GIR_IDX_W-1:0] GIR_CAUSE_BASE_IDX = 10'h200;
   localparam logic [GIR_IDX_W-1:0] GIR_CAUSE_LAST_IDX = 10'h20c;
   localparam int GIR_IDX_STRIDE_LOG2 = 2;
   localparam int GIR_LEVEL_MSB = 31;
   localparam int GIR_LEVEL_LSB = 30;
   localparam int GIR_OFFSET_MSB = 13;
   localparam logic [GIR_PRIO_W-1:0] GIR_PRIO_RESET = 16'h0000;
   localparam logic [GIR_LEVEL_W-1:0] GIR_TOP_LEVEL = 2'h3;
   localparam int GIR_SYSREG_GROUP = 0;
   localparam int GIR_DMA_FIRST_GROUP = 4;
   localparam int GIR_DMA_LINES_PER_GROUP = 4;
   localparam int GIR_DMA_CHANNELS = 12;
   localparam int GIR_PWR_GROUP = 7;
   localparam int GIR_EXT_FIRST_GROUP = 8;
endpackage

//--- verilog/gir_sel_if.sv
// Carrier between the register block and the request prioritizer.
`timescale 1ns/1ps
interface gir_sel_if #(
   parameter int NG = gir_pkg::GIR_MAX_GROUPS
);
   logic [NG-1:0] grp_req;
   logic [NG-1:0][gir_pkg::GIR_LEVEL_W-1:0] grp_level;
   logic global_mask;
   logic [gir_pkg::GIR_NUM_LEVELS-1:0] level_mask;
   logic [gir_pkg::GIR_NUM_LEVELS-1:0] level_any;
   logic [gir_pkg::GIR_NUM_LEVELS-1:0][gir_pkg::GIR_GROUP_W-1:0] level_cause;
   logic win_valid;
   logic [gir_pkg::GIR_LEVEL_W-1:0] win_level;
   logic [gir_pkg::GIR_GROUP_W-1:0] win_group;
   modport calc (
      input grp_req,
      input grp_level,
      input global_mask,
      input level_mask,
      output level_any,
      output level_cause,
      output win_valid,
      output win_level,
      output win_group
   );
   modport user (
      output grp_req,
      output grp_level,
      output global_mask,
      output level_mask,
      input level_any,
      input level_cause,
      input win_valid,
      input win_level,
      input win_group
   );
endinterface // gir_sel_if

//--- verilog/gir_prio.sv
// Masking and priority selection over the group requests.
`timescale 1ns/1ps
module gir_prio #(
   parameter int NG = gir_pkg::GIR_MAX_GROUPS
) (
   gir_sel_if.calc sel
);
   import gir_pkg::*;

   logic [NG-1:0] valid_req;
   logic [GIR_NUM_LEVELS-1:0][NG-1:0] at_level;
   logic [NG-1:0] vm;

   function automatic logic [GIR_GROUP_W-1:0] lowest(input logic [NG-1:0] v);
      logic [GIR_GROUP_W-1:0] r;
      r = '0;
      for (int g = NG - 1; g >= 0; g--) begin
         if (v[g]) begin
            r = GIR_GROUP_W'(g);
         end
      end
      return r;
   endfunction

   for (genvar g = 0; g < NG; g++) begin : g_grp
      for (genvar l = 0; l < GIR_NUM_LEVELS; l++) begin : g_lvl
         assign at_level[l][g] = sel.grp_req[g] && (sel.grp_level[g] == GIR_LEVEL_W'(l));
      end
      // Masked when the global mask or the mask of the group's level is set.
      assign valid_req[g] = sel.grp_req[g] && !sel.global_mask && !sel.level_mask[sel.grp_level[g]];
   end

   always_comb begin
      vm = '0;
      sel.win_valid = 1'b0;
      sel.win_level = '0;
      sel.win_group = '0;
      for (int l = 0; l < GIR_NUM_LEVELS; l++) begin
         sel.level_any[l] = |at_level[l];
         sel.level_cause[l] = lowest(at_level[l]);
         vm = at_level[l] & valid_req;
         // Later, higher levels override; lowest group wins within a level.
         if (|vm) begin
            sel.win_valid = 1'b1;
            sel.win_level = GIR_LEVEL_W'(l);
            sel.win_group = lowest(vm);
         end
      end
   end
endmodule // gir_prio

//--- verilog/gir_top.sv
// Grouped interrupt register block: request sampling, APB registers, processor request.
// Behaviour
// - Up to 64 groups of 32 lines, each line mirrored by one request bit.
// - Two-bit level code 00 lowest through 11 highest.
// - Fourteen-bit handler offset in bits 13:0 is sent when group is selected.
// - Request bit reads one while its line is pending, else zero.
// - Request bits are sampled continuously and ignore writes.
// - Four cause registers, one per level, return the group number.
// - Cause for level n is the lowest pending group assigned to level n.
// - Cause value is only meaningful while its level has a pending request.
// - All lines of a group share the group's level and offset.
// - Fixed wiring of compare, twelve DMA channels and power request sources.
// - Register interface runs on the bus interface clock, apart from sampling; here registers and sampling both run on CORE_CLK.
// - Group request is the OR of all its lines.
// - Group request masked by global mask or its level's mask.
// - Non-maskable wins, then highest level, then lowest group.
// - Three sampling cycles from request line to processor request.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module gir_top #(
   parameter int NUM_GROUPS = gir_pkg::GIR_MAX_GROUPS
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [gir_pkg::GIR_ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SYSREG_CMP_REQ,
   input wire logic [gir_pkg::GIR_DMA_CHANNELS-1:0] DMA_CH_REQ,
   input wire logic PWR_MGR_REQ,
   input wire logic [(NUM_GROUPS-gir_pkg::GIR_EXT_FIRST_GROUP)*gir_pkg::GIR_LINES_PER_GROUP-1:0] EXT_REQ,
   input wire logic NMI_REQ,
   input wire logic CPU_GLOBAL_MASK,
   input wire logic [gir_pkg::GIR_NUM_LEVELS-1:0] CPU_LEVEL_MASK,
   output logic IRQ_REQ,
   output logic IRQ_NMI,
   output logic [gir_pkg::GIR_LEVEL_W-1:0] IRQ_LEVEL,
   output logic [gir_pkg::GIR_OFFSET_W-1:0] IRQ_HANDLER_OFFSET
);
   import gir_pkg::*;

   localparam int NL = NUM_GROUPS * GIR_LINES_PER_GROUP;

   typedef struct packed {
      logic [NL-1:0] sync1;
      logic [NL-1:0] lines;
      logic [NUM_GROUPS-1:0][GIR_PRIO_W-1:0] prio;
      logic nmi1;
      logic nmi2;
      logic [31:0] rdata;
      logic slverr;
      logic irq_req;
      logic irq_nmi;
      logic [GIR_LEVEL_W-1:0] irq_level;
      logic [GIR_OFFSET_W-1:0] irq_off;
   } gir_state_t;

   gir_state_t q;
   gir_state_t d;
   logic [NL-1:0] raw;
   logic [GIR_IDX_W-1:0] idx;
   logic [GIR_IDX_W-1:0] rel_lines;
   logic [GIR_IDX_W-1:0] rel_cause;
   logic word_ok;
   logic hit_prio;
   logic hit_lines;
   logic hit_cause;
   int unsigned prio_n;
   int unsigned lines_n;
   int unsigned cause_lvl;
   logic [31:0] rd;

   gir_sel_if #(.NG(NUM_GROUPS)) sel ();

   gir_prio #(.NG(NUM_GROUPS)) u_prio (
      .sel(sel)
   );

   // Fixed source wiring; every line with no source stays zero.
   always_comb begin
      raw = '0;
      raw[GIR_SYSREG_GROUP*GIR_LINES_PER_GROUP] = SYSREG_CMP_REQ;
      for (int c = 0; c < GIR_DMA_CHANNELS; c++) begin
         raw[(GIR_DMA_FIRST_GROUP + c / GIR_DMA_LINES_PER_GROUP) * GIR_LINES_PER_GROUP
             + c % GIR_DMA_LINES_PER_GROUP] = DMA_CH_REQ[c];
      end
      raw[GIR_PWR_GROUP*GIR_LINES_PER_GROUP] = PWR_MGR_REQ;
      raw[NL-1:GIR_EXT_FIRST_GROUP*GIR_LINES_PER_GROUP] = EXT_REQ;
   end

   // Group request and its shared level, one per group.
   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
      assign sel.grp_req[g] = |q.lines[g*GIR_LINES_PER_GROUP +: GIR_LINES_PER_GROUP];
      assign sel.grp_level[g] = q.prio[g][GIR_PRIO_W-1:GIR_OFFSET_W];
   end
   // The processor masks come from logic on this clock, so they are used directly.
   assign sel.global_mask = CPU_GLOBAL_MASK;
   assign sel.level_mask = CPU_LEVEL_MASK;

   // Address decode: printed offsets are word indices with a stride of four indices.
   always_comb begin
      idx = PADDR[GIR_ADDR_W-1:GIR_IDX_STRIDE_LOG2];
      word_ok = (PADDR[GIR_IDX_STRIDE_LOG2-1:0] == '0);
      rel_lines = idx - GIR_LINES_BASE_IDX;
      rel_cause = idx - GIR_CAUSE_BASE_IDX;
      prio_n = 32'(idx >> GIR_IDX_STRIDE_LOG2);
      lines_n = 32'(rel_lines >> GIR_IDX_STRIDE_LOG2);
      cause_lvl = (GIR_NUM_LEVELS - 1) - 32'(rel_cause >> GIR_IDX_STRIDE_LOG2);
      hit_prio = word_ok && (idx >= GIR_PRIO_BASE_IDX) && (idx[GIR_IDX_STRIDE_LOG2-1:0] == '0)
                 && (prio_n < NUM_GROUPS);
      hit_lines = word_ok && (idx >= GIR_LINES_BASE_IDX) && (rel_lines[GIR_IDX_STRIDE_LOG2-1:0] == '0)
                  && (lines_n < NUM_GROUPS);
      hit_cause = word_ok && (idx >= GIR_CAUSE_BASE_IDX) && (idx <= GIR_CAUSE_LAST_IDX)
                  && (rel_cause[GIR_IDX_STRIDE_LOG2-1:0] == '0);
   end

   // Read data mux; fields not listed read as zero.
   always_comb begin
      rd = '0;
      if (hit_prio) begin
         rd[GIR_LEVEL_MSB:GIR_LEVEL_LSB] = q.prio[prio_n][GIR_PRIO_W-1:GIR_OFFSET_W];
         rd[GIR_OFFSET_MSB:0] = q.prio[prio_n][GIR_OFFSET_W-1:0];
      end else if (hit_lines) begin
         rd = q.lines[lines_n*GIR_LINES_PER_GROUP +: GIR_LINES_PER_GROUP];
      end else if (hit_cause) begin
         // The cause reads zero while its level has nothing pending, so software never sees a stale group.
         if (sel.level_any[cause_lvl]) begin
            rd[GIR_GROUP_W-1:0] = sel.level_cause[cause_lvl];
         end
      end
   end

   always_comb begin
      d = q;
      // Two-stage sampling of the request pins; the second stage is the readable copy.
      d.sync1 = raw;
      d.lines = q.sync1;
      d.nmi1 = NMI_REQ;
      d.nmi2 = q.nmi1;
      // Capture read data in the setup cycle so the access cycle answers at once.
      if (PSEL && !PENABLE) begin
         d.rdata = PWRITE ? '0 : rd;
         d.slverr = !(hit_prio || hit_lines || hit_cause);
      end
      // Writes land only in the priority registers; request and cause words ignore them.
      if (PSEL && PENABLE && PWRITE && hit_prio) begin
         d.prio[prio_n] = {PWDATA[GIR_LEVEL_MSB:GIR_LEVEL_LSB], PWDATA[GIR_OFFSET_MSB:0]};
      end
      // Third stage: registered request towards the processor.
      if (q.nmi2) begin
         d.irq_req = 1'b1;
         d.irq_nmi = 1'b1;
         d.irq_level = GIR_TOP_LEVEL;
         d.irq_off = '0;
      end else begin
         d.irq_req = sel.win_valid;
         d.irq_nmi = 1'b0;
         d.irq_level = sel.win_level;
         d.irq_off = q.prio[sel.win_group][GIR_OFFSET_W-1:0];
      end
   end

   // The register file and sampling share CORE_CLK in this build.
   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign PREADY = 1'b1;
   assign PRDATA = q.rdata;
   assign PSLVERR = q.slverr;
   assign IRQ_REQ = q.irq_req;
   assign IRQ_NMI = q.irq_nmi;
   assign IRQ_LEVEL = q.irq_level;
   assign IRQ_HANDLER_OFFSET = q.irq_off;
endmodule // gir_top

//--- tb/gir_top_assertions.sv
// Port checker for the grouped interrupt register block.
`timescale 1ns/1ps
module gir_chk (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [gir_pkg::GIR_ADDR_W-1:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PSLVERR,
   input wire logic NMI_REQ,
   input wire logic CPU_GLOBAL_MASK,
   input wire logic [gir_pkg::GIR_NUM_LEVELS-1:0] CPU_LEVEL_MASK,
   input wire logic IRQ_REQ,
   input wire logic IRQ_NMI,
   input wire logic [gir_pkg::GIR_LEVEL_W-1:0] IRQ_LEVEL,
   input wire logic [gir_pkg::GIR_OFFSET_W-1:0] IRQ_HANDLER_OFFSET
);
   import gir_pkg::*;
   logic [GIR_NUM_LEVELS-1:0] lm_q;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   sequence s_setup; PSEL && !PENABLE; endsequence
   sequence s_nmi_held; NMI_REQ [*3]; endsequence
   // Masks act one edge late, so a presented level is judged against last cycle's mask.
   always_ff @(posedge CORE_CLK) lm_q <= CPU_LEVEL_MASK;
   chk_bad_align: assert property (s_setup ##0 PADDR[1:0] != 2'h0 |=> PSLVERR)
      else $error("misaligned access without error");
   chk_err_data: assert property (PSLVERR |-> PRDATA == 32'h0)
      else $error("error response with data");
   chk_write_data: assert property (s_setup ##0 PWRITE |=> PRDATA == 32'h0)
      else $error("write returned data");
   chk_rdata_hold: assert property (PSEL && PENABLE |=> $stable(PRDATA))
      else $error("read data moved");
   chk_nmi_fields: assert property (IRQ_NMI |-> IRQ_REQ && IRQ_LEVEL == GIR_TOP_LEVEL && IRQ_HANDLER_OFFSET == 14'h0)
      else $error("bad nmi presentation");
   chk_nmi_delay: assert property (s_nmi_held |=> IRQ_NMI)
      else $error("nmi late");
   chk_global_quiet: assert property ((CPU_GLOBAL_MASK && !NMI_REQ) [*3] |=> !IRQ_REQ)
      else $error("request passed global mask");
   chk_level_mask: assert property (IRQ_REQ && !IRQ_NMI |-> !$past(CPU_GLOBAL_MASK) && !lm_q[IRQ_LEVEL])
      else $error("request passed level mask");
endmodule // gir_chk
bind gir_top gir_chk u_chk (.CORE_CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PSLVERR, .NMI_REQ,
   .CPU_GLOBAL_MASK, .CPU_LEVEL_MASK, .IRQ_REQ, .IRQ_NMI, .IRQ_LEVEL, .IRQ_HANDLER_OFFSET);

//--- tb/gir_cpu_model.sv
// Behavioural processor core that owns the interrupt mask bits.
`timescale 1ns/1ps
module gir_cpu_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic gm_cmd,
   input wire logic [gir_pkg::GIR_NUM_LEVELS-1:0] lm_cmd,
   input wire logic take,
   input wire logic irq_req,
   input wire logic irq_nmi,
   input wire logic [gir_pkg::GIR_LEVEL_W-1:0] irq_level,
   output logic global_mask,
   output logic [gir_pkg::GIR_NUM_LEVELS-1:0] level_mask
);
   import gir_pkg::*;
   logic [GIR_NUM_LEVELS-1:0] auto_q;
   // Taking a request masks its level and all below, so the same source cannot re-enter.
   always_ff @(posedge clk) begin
      if (!rst_n) auto_q <= 4'h0;
      else if (take && irq_req && !irq_nmi) auto_q <= auto_q | 4'((8'h2 << irq_level) - 8'h1);
      global_mask <= rst_n && gm_cmd;
      level_mask <= rst_n ? (lm_cmd | auto_q) : 4'h0;
   end
endmodule // gir_cpu_model

//--- tb/testbench.sv
// Self-checking bench for the grouped interrupt register block.
`timescale 1ns/1ps
`define CMP(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
   import gir_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, sysreg = 0, pwr = 0, nmi = 0, gm = 0, take = 0, look = 0;
   logic [11:0] paddr = 0, dma = 0;
   logic [31:0] pwdata = 0, ext = 0, prdata;
   logic [3:0] lm = 0, lmask;
   logic gmask, pready, pslverr, irq_req, irq_nmi;
   logic [1:0] irq_lvl;
   logic [13:0] irq_off, off4, off5, off6;
   logic [32:0] expq[$], ex;
   int n_mismatch = 0, checks = 0, cyc = 0;
   always #5 clk = ~clk;
   gir_top #(.NUM_GROUPS(9)) dut (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SYSREG_CMP_REQ(sysreg),
      .DMA_CH_REQ(dma), .PWR_MGR_REQ(pwr), .EXT_REQ(ext), .NMI_REQ(nmi), .CPU_GLOBAL_MASK(gmask),
      .CPU_LEVEL_MASK(lmask), .IRQ_REQ(irq_req), .IRQ_NMI(irq_nmi), .IRQ_LEVEL(irq_lvl), .IRQ_HANDLER_OFFSET(irq_off));
   gir_cpu_model cpu (.clk(clk), .rst_n(rstn), .gm_cmd(gm), .lm_cmd(lm), .take(take), .irq_req(irq_req),
      .irq_nmi(irq_nmi), .irq_level(irq_lvl), .global_mask(gmask), .level_mask(lmask));
   task automatic tally_and_finish();
      if (n_mismatch == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (psel && penable && pready && !pwrite) begin
         ex = expq.pop_front();
         `CMP("read", ex, {pslverr, prdata})
      end
      if (look) begin
         ex = expq.pop_front();
         `CMP("irq", ex, {15'h0, irq_nmi, irq_req, irq_lvl, irq_off})
      end
      if (cyc == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      expq.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   // Outputs follow pins within three edges, so four edges always leaves them settled.
   task automatic see(input logic [32:0] e);
      repeat (4) @(posedge clk);
      expq.push_back(e);
      look <= 1'b1;
      @(posedge clk);
      look <= 1'b0;
   endtask
   function automatic logic [11:0] pa(input int n); return 12'(n * 16); endfunction
   function automatic logic [11:0] ra(input int n); return 12'(12'h3fc + n * 16); endfunction
   initial begin
      void'($urandom(55952));
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int n = 0; n < 9; n++) rd(pa(n), 33'h0);
      rd(pa(9), {1'b1, 32'h0});
      rd(12'h002, {1'b1, 32'h0});
      off4 = 14'($urandom) & 14'h3ffe;
      off5 = 14'($urandom) & 14'h3ffe;
      off6 = 14'($urandom) & 14'h3ffe;
      xfer(1'b1, pa(1), 32'hffffffff);
      rd(pa(1), 33'h0c0003fff);
      xfer(1'b1, pa(4), {2'h1, 16'h0, off4});
      xfer(1'b1, pa(5), {2'h2, 16'h0, off5});
      xfer(1'b1, pa(6), {2'h3, 16'h0, off6});
      rd(pa(4), {3'h1, 16'h0, off4});
      dma <= 12'($urandom);
      ext <= $urandom;
      pwr <= 1'b1;
      sysreg <= 1'b1;
      repeat (3) @(posedge clk);
      for (int g = 0; g < 3; g++) rd(ra(4 + g), {29'h0, dma[4*g +: 4]});
      rd(ra(0), 33'h1);
      rd(ra(7), 33'h1);
      rd(ra(1), 33'h0);
      xfer(1'b1, ra(8), ~ext);
      rd(ra(8), {1'b0, ext});
      dma <= 12'hfff;
      xfer(1'b1, 12'h800, 32'h3f);
      repeat (3) @(posedge clk);
      for (int l = 0; l < 4; l++) rd(12'(12'h830 - l * 16), {27'h0, 6'(l == 0 ? 0 : l + 3)});
      see({15'h0, 1'b0, 1'b1, 2'h3, off6});
      lm <= 4'h8;
      see({15'h0, 1'b0, 1'b1, 2'h2, off5});
      take <= 1'b1;
      @(posedge clk);
      take <= 1'b0;
      lm <= 4'h0;
      see({15'h0, 1'b0, 1'b1, 2'h3, off6});
      gm <= 1'b1;
      repeat (4) @(posedge clk);
      nmi <= 1'b1;
      see({15'h0, 1'b1, 1'b1, 2'h3, 14'h0});
      repeat (2) @(posedge clk);
      tally_and_finish();
   end
endmodule // testbench
